// ### src/sequencer_pkg.sv
// shared constants and types for the program sequencer
// Functional notes
// - four non-overlapping phases make one instruction cycle of four clocks
// - fetch in one cycle, execute in the next, one-cycle throughput
// - any program counter change costs two cycles through a dummy cycle
// - program counter is twelve bits, 4096 words
// - after each fetch the program counter advances by one
// - true skip discards the prefetched word, dummy cycle, continue at plus two
// - low byte at data address 06H readable; write replaces bits 7..0 only
// - jumps, calls, skips, low-byte writes, reset, interrupts, returns load the counter
// - return reloads all twelve bits from the top stack entry
// - program memory words are fifteen bits wide
// - reset clears the program counter to 000H
// - first external interrupt vectors to 004H when enabled and stack not full
// - second external interrupt vectors to 008H when enabled and stack not full
// - first timer overflow vectors to 00CH when enabled and stack not full
// - second timer overflow vectors to 010H when enabled and stack not full
// - time base interrupt vectors to 014H when enabled and stack not full
// - real time clock interrupt vectors to 018H when enabled and stack not full
// - six-level return stack; calls and acknowledges push, returns pop
// - stack full: request stays pending, acknowledge waits for a return
package sequencer_pkg;

  localparam int PC_W        = 12;           // program counter width
  localparam int INSTR_W     = 15;           // program word width
  localparam int STACK_DEPTH = 6;            // return stack levels
  localparam int IRQ_N       = 6;            // interrupt sources
  localparam int DADDR_W     = 8;            // data address width
  localparam int DATA_W      = 8;            // data bus width

  localparam logic [DADDR_W-1:0] LOW_BYTE_ADDR = 8'h06; // low byte of program counter
  localparam logic [PC_W-1:0]    RESET_PC  = 12'h000; // start address
  localparam logic [PC_W-1:0]    PC_STEP   = 12'h001; // sequential advance

  // vectors, index 0 has the lowest address and the highest priority
  localparam logic [IRQ_N-1:0][PC_W-1:0] IRQ_VECTORS = {
    12'h018,  // real time clock
    12'h014,  // time base
    12'h010,  // timer_counter_second overflow
    12'h00c,  // timer_counter_first overflow
    12'h008,  // external_irq_second
    12'h004   // external_irq_first
  };

  // one phase per system clock inside an instruction cycle
  typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} phase_t;

  // flow class of the instruction being executed, from the decoder
  typedef enum logic [2:0] {FLOW_NONE, FLOW_SKIP, FLOW_JUMP, FLOW_CALL, FLOW_RET} flow_kind_t;

  // decoder verdict for the instruction in execute
  typedef struct packed {
    flow_kind_t       kind;      // flow class
    logic             skip_met;  // skip condition true
    logic [PC_W-1:0]  target;    // jump or call address
  } flow_ctrl_t;

  // data bus access towards the low byte register
  typedef struct packed {
    logic [DADDR_W-1:0] addr;   // data address
    logic               wr;     // write strobe, one cycle
    logic [DATA_W-1:0]  wdata;  // write data
  } data_bus_t;

endpackage

// ### src/return_stack.sv
// return address stack, oldest entry dropped on overflow
`timescale 1ns/1ps
`default_nettype none
module return_stack
  import sequencer_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int W     = PC_W
)(
  input  wire logic         clk,    // system clock
  input  wire logic         reset,  // synchronous, active high
  input  wire logic         push,   // store push_data on top
  input  wire logic         pop,    // drop top entry
  input  wire logic [W-1:0] push_data, // address to save
  output logic      [W-1:0] top,    // newest entry
  output logic              full    // all levels used
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] entry;  // entry 0 is the top
    logic [$clog2(DEPTH+1)-1:0] count;
  } stack_state_t;

  localparam logic [$clog2(DEPTH+1)-1:0] FULL_COUNT = ($clog2(DEPTH+1))'(DEPTH);
  localparam logic [$clog2(DEPTH+1)-1:0] ONE_COUNT  = ($clog2(DEPTH+1))'(1);

  stack_state_t st_reg;
  stack_state_t st_next;

  // shift register stack: a push while full pushes the oldest out the bottom
  always_comb
  begin
    st_next = st_reg;
    if (push)
    begin
      st_next.entry = {st_reg.entry[DEPTH-2:0], push_data};
      if (st_reg.count != FULL_COUNT)
        st_next.count = st_reg.count + ONE_COUNT;
    end
    else if (pop)
    begin
      st_next.entry = {{W{1'b0}}, st_reg.entry[DEPTH-1:1]};
      if (st_reg.count != '0)
        st_next.count = st_reg.count - ONE_COUNT;
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (reset)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign top  = st_reg.entry[0];
  assign full = (st_reg.count == FULL_COUNT);

endmodule
`default_nettype wire

// ### src/program_sequencer.sv
// instruction cycle, fetch/execute pipeline and program counter control
`timescale 1ns/1ps
`default_nettype none
module program_sequencer
  import sequencer_pkg::*;
#(
  parameter int IRQS = IRQ_N
)(
  input  wire logic               clk,            // system clock, 250 MHz
  input  wire logic               reset,          // synchronous, active high
  output logic [PC_W-1:0]         rom_addr,       // program memory address
  input  wire logic [INSTR_W-1:0] rom_data,       // program word, sampled in phase 4
  output logic [INSTR_W-1:0]      instr,          // word in execute
  output logic                    instr_valid,    // low during a dummy cycle
  output logic [3:0]              phase,          // one-hot phase, bit 0 first
  output logic                    exec_end,       // pulse in phase 4 of a real instruction
  input  wire flow_ctrl_t         flow,           // decoder verdict, sampled in phase 4
  input  wire data_bus_t          dbus,           // data bus from the executing instruction
  output logic [DATA_W-1:0]       pc_low_byte,    // read value of address 06H
  input  wire logic [IRQS-1:0]    irq_req,        // pending request flags
  input  wire logic [IRQS-1:0]    irq_en,         // per-source enables
  output logic [IRQS-1:0]         irq_ack,        // one-hot acknowledge pulse
  output logic                    stack_full      // no free stack level
);

  // every piece of state in one record
  typedef struct packed {
    phase_t              ph;       // current phase
    logic [PC_W-1:0]     pc;       // address being fetched
    logic [INSTR_W-1:0]  ir;       // word in execute
    logic                ir_valid; // ir holds a real instruction
    logic [3:0]          ph_onehot;
    logic                exec_end;
    logic [IRQS-1:0]     ack;
    logic                full;
  } seq_state_t;

  seq_state_t st_reg;
  seq_state_t st_next;

  // stack handshake, driven from the next-state logic
  logic            push;
  logic            pop;
  logic [PC_W-1:0] push_data;
  logic [PC_W-1:0] stack_top;
  logic            stack_full_w;

  // interrupt selection and low byte write decode
  logic [IRQS-1:0] pending;
  logic [IRQS-1:0] pick;
  logic [PC_W-1:0] vector;
  logic            irq_take;
  logic            low_byte_wr;

  // one-hot phase codes, bit 0 is the first phase
  localparam logic [3:0] PH_CODE_T1 = 4'h1;
  localparam logic [3:0] PH_CODE_T2 = 4'h2;
  localparam logic [3:0] PH_CODE_T3 = 4'h4;
  localparam logic [3:0] PH_CODE_T4 = 4'h8;

  // six-level stack for calls and interrupt entries
  return_stack #(
    .DEPTH (STACK_DEPTH),
    .W     (PC_W)
  ) u_stack (
    .clk       (clk),
    .reset     (reset),
    .push      (push),
    .pop       (pop),
    .push_data (push_data),
    .top       (stack_top),
    .full      (stack_full_w)
  );

  // fixed priority: lowest index, lowest vector address wins
  always_comb
  begin
    pending = irq_req & irq_en;
    pick    = '0;
    vector  = RESET_PC;
    // runs high to low so the lowest index is written last and wins
    for (int i = IRQS - 1; i >= 0; i--)
    begin
      if (pending[i])
      begin
        pick   = '0;
        pick[i] = 1'b1;
        vector = IRQ_VECTORS[i];
      end
    end
  end

  // next-state logic; the phase steps every clock, the counter and the word in execute move on the phase 4 edge
  always_comb
  begin
    st_next          = st_reg;
    st_next.ack      = '0;
    st_next.exec_end = 1'b0;
    // registered copy keeps the output pin off the stack compare
    st_next.full     = stack_full_w;
    push             = 1'b0;
    pop              = 1'b0;
    push_data        = st_reg.pc;
    irq_take         = 1'b0;
    low_byte_wr      = st_reg.ir_valid && dbus.wr && (dbus.addr == LOW_BYTE_ADDR);
    case (st_reg.ph)
      PH_T1:
      begin
        st_next.ph        = PH_T2;
        st_next.ph_onehot = PH_CODE_T2;
      end
      PH_T2:
      begin
        st_next.ph        = PH_T3;
        st_next.ph_onehot = PH_CODE_T3;
      end
      PH_T3:
      begin
        st_next.ph        = PH_T4;
        st_next.ph_onehot = PH_CODE_T4;
        // raised a phase early so the register stands in phase 4
        st_next.exec_end  = st_reg.ir_valid;
      end
      PH_T4:
      begin
        st_next.ph        = PH_T1;
        st_next.ph_onehot = PH_CODE_T1;
        // default: the fetched word goes to execute, the counter steps
        st_next.ir        = rom_data;
        st_next.ir_valid  = 1'b1;
        st_next.pc        = st_reg.pc + PC_STEP;
        if (st_reg.ir_valid)
        begin
          // a dummy cycle skips all of this and only takes the default step above
          case (flow.kind)
            FLOW_SKIP:
            begin
              // the default step already moves the counter past the skipped word
              if (flow.skip_met)
                st_next.ir_valid = 1'b0;
            end
            FLOW_JUMP:
            begin
              // all twelve bits come from the instruction word
              st_next.pc       = flow.target;
              st_next.ir_valid = 1'b0;
            end
            FLOW_CALL:
            begin
              // saves the address after the call, already in the counter
              push             = 1'b1;
              st_next.pc       = flow.target;
              st_next.ir_valid = 1'b0;
            end
            FLOW_RET:
            begin
              // no underflow check: an empty stack returns to address zero
              pop              = 1'b1;
              st_next.pc       = stack_top;
              st_next.ir_valid = 1'b0;
            end
            default:
            begin
              // a low byte write is a short jump inside the current page
              if (low_byte_wr)
              begin
                st_next.pc       = {st_reg.pc[PC_W-1:DATA_W], dbus.wdata};
                st_next.ir_valid = 1'b0;
              end
              else if ((pending != '0) && !stack_full_w)
              begin
                // taken only after a plain instruction; a full stack holds it off
                irq_take = 1'b1;
              end
            end
          endcase
          if (irq_take)
          begin
            // inserted call: the prefetched word is dropped and refetched on return
            push             = 1'b1;
            st_next.pc       = vector;
            st_next.ir_valid = 1'b0;
            st_next.ack      = pick;
          end
        end
      end
      default:
      begin
        st_next.ph        = PH_T1;
        st_next.ph_onehot = PH_CODE_T1;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_reg           <= '0;
      st_reg.ph        <= PH_T1;
      // the phase record must start in the first phase, not at all zeros
      st_reg.ph_onehot <= PH_CODE_T1;
      st_reg.pc        <= RESET_PC;
      st_reg.ir_valid  <= 1'b0;
    end
    else
      st_reg <= st_next;
  end

  // outputs straight from the state record
  assign rom_addr    = st_reg.pc;
  assign instr       = st_reg.ir;
  assign instr_valid = st_reg.ir_valid;
  assign phase       = st_reg.ph_onehot;
  assign exec_end    = st_reg.exec_end;
  // the read sees the fetch counter, one word ahead of the executing one
  assign pc_low_byte = st_reg.pc[DATA_W-1:0];
  assign irq_ack     = st_reg.ack;
  assign stack_full  = st_reg.full;

endmodule
`default_nettype wire

// ### sim/program_sequencer_checker.sv
// concurrent checks on the sequencer's ports
`timescale 1ns/1ps
`default_nettype none
module program_sequencer_checker
  import sequencer_pkg::*;
#(
  parameter int IRQS = IRQ_N
)(
  input wire logic               clk,         // clock
  input wire logic               reset,       // sync reset
  input wire logic [PC_W-1:0]    rom_addr,    // fetch address
  input wire logic [INSTR_W-1:0] rom_data,    // program word
  input wire logic [INSTR_W-1:0] instr,       // word in execute
  input wire logic               instr_valid, // real instruction
  input wire logic [3:0]         phase,       // one-hot phase
  input wire logic               exec_end,    // T4 pulse
  input wire flow_ctrl_t         flow,        // decoder verdict
  input wire data_bus_t          dbus,        // data bus
  input wire logic [DATA_W-1:0]  pc_low_byte, // low byte read
  input wire logic [IRQS-1:0]    irq_req,     // request flags
  input wire logic [IRQS-1:0]    irq_en,      // enables
  input wire logic [IRQS-1:0]    irq_ack,     // acknowledge
  input wire logic               stack_full   // stack full
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // qualifiers that keep a plain step apart from a load
  wire low_byte_wr = dbus.wr && dbus.addr == LOW_BYTE_ADDR;
  wire irq_any = |(irq_req & irq_en);
  property p_rot; 1'b1 |=> phase == {$past(phase[2:0]), $past(phase[3])}; endproperty
  a_rot: assert property (p_rot) else $error("phase order broken");
  property p_hold; !phase[0] |-> $stable(rom_addr) && $stable(instr_valid); endproperty
  a_hold: assert property (p_hold) else $error("fetch moved mid cycle");
  property p_exe; exec_end |-> phase == 4'h8 && instr_valid; endproperty
  a_exe: assert property (p_exe) else $error("exec pulse misplaced");
  property p_seq; exec_end && flow.kind == FLOW_NONE && !low_byte_wr && !irq_any
    |=> rom_addr == $past(rom_addr) + 12'h001 && instr_valid && instr == $past(rom_data); endproperty
  a_seq: assert property (p_seq) else $error("sequential step wrong");
  property p_jmp; exec_end && flow.kind inside {FLOW_JUMP, FLOW_CALL}
    |=> rom_addr == $past(flow.target) && !instr_valid; endproperty
  a_jmp: assert property (p_jmp) else $error("jump load wrong");
  property p_skip; exec_end && flow.kind == FLOW_SKIP && flow.skip_met
    |=> rom_addr == $past(rom_addr) + 12'h001 && !instr_valid; endproperty
  a_skip: assert property (p_skip) else $error("skip wrong");
  property p_lbw; exec_end && flow.kind == FLOW_NONE && low_byte_wr
    |=> rom_addr == {$past(rom_addr[11:8]), $past(dbus.wdata)} && !instr_valid; endproperty
  a_lbw: assert property (p_lbw) else $error("short jump wrong");
  property p_lbr; !phase[0] |-> pc_low_byte == rom_addr[7:0]; endproperty
  a_lbr: assert property (p_lbr) else $error("low byte read wrong");
  property p_ack; |irq_ack |-> $onehot(irq_ack) && phase == 4'h1 && !instr_valid; endproperty
  a_ack: assert property (p_ack) else $error("acknowledge malformed");
  property p_full; exec_end && stack_full |=> irq_ack == '0; endproperty
  a_full: assert property (p_full) else $error("ack while stack full");
  property p_dummy; phase == 4'h8 && !instr_valid
    |=> rom_addr == $past(rom_addr) + 12'h001 && instr_valid && irq_ack == '0; endproperty
  a_dummy: assert property (p_dummy) else $error("dummy cycle acted");
endmodule
bind program_sequencer program_sequencer_checker #(.IRQS(IRQS)) chk (.clk, .reset, .rom_addr, .rom_data,
  .instr, .instr_valid, .phase, .exec_end, .flow, .dbus, .pc_low_byte, .irq_req, .irq_en, .irq_ack, .stack_full);
`default_nettype wire

// ### sim/rom_irq_model.sv
// program memory and interrupt request flags
`timescale 1ns/1ps
`default_nettype none
module rom_irq_model
  import sequencer_pkg::*;
(
  input wire logic                clk,      // clock
  input wire logic                reset,    // sync reset
  input wire logic [PC_W-1:0]     rom_addr, // fetch address
  output logic     [INSTR_W-1:0]  rom_data, // program word
  input wire logic [IRQ_N-1:0]    irq_set,  // source events
  input wire logic [IRQ_N-1:0]    irq_ack,  // acknowledge
  output logic     [IRQ_N-1:0]    irq_req   // request flags
);
  // word tagged with its own address so fetches are traceable
  assign rom_data = {3'b101, rom_addr};
  // flag stays set until acknowledged; a new event beats a same-cycle acknowledge
  always_ff @(posedge clk)
    irq_req <= reset ? '0 : (irq_req & ~irq_ack) | irq_set;
endmodule
`default_nettype wire

// ### sim/program_sequencer_tb.sv
// self-checking bench for the program sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; $display("Error at %0t: %h vs %h", $time, g, e); end end
module program_sequencer_tb
  import sequencer_pkg::*;
;
  logic               clk = 1'b0;                // clock
  logic               reset = 1'b1;              // sync reset
  logic [PC_W-1:0]    rom_addr, last_a, ra;      // addresses
  logic [INSTR_W-1:0] rom_data, instr;           // words
  logic               instr_valid, exec_end, stack_full;
  logic [3:0]         phase;                     // one-hot phase
  flow_ctrl_t         flow = '0;                 // decoder verdict
  data_bus_t          dbus = '0;                 // data bus
  logic [7:0]         pc_low_byte;               // low byte read
  logic [5:0]         irq_req, irq_ack, irq_set = '0, irq_en = 6'h3f;
  int                 fails = 0, checked = 0;    // counters
  always #2 clk = ~clk;
  program_sequencer dut (.clk, .reset, .rom_addr, .rom_data, .instr, .instr_valid, .phase,
    .exec_end, .flow, .dbus, .pc_low_byte, .irq_req, .irq_en, .irq_ack, .stack_full);
  rom_irq_model mem (.clk, .reset, .rom_addr, .rom_data, .irq_set, .irq_ack, .irq_req);
  task automatic final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic do_reset;
    reset = 1'b1;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    `CHK(rom_addr, 12'h000)
    `CHK(phase, 4'h1)
  endtask
  task automatic raise(input logic [5:0] m);
    irq_set = m;
    @(negedge clk);
    irq_set = '0;
  endtask
  // one decision at the next real T4, judged in the following T1
  task automatic step(input flow_kind_t k, input logic m, input logic [11:0] t, input logic [7:0] da,
                      input logic rel, input logic [11:0] ea, input logic ev, input logic [5:0] eack);
    int n;
    n = 0;
    while (!(phase === 4'h8 && instr_valid === 1'b1) && n < 64)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 64)
    begin
      fails++;
      $display("Error at %0t: no real phase 4 seen", $time);
    end
    last_a = rom_addr;
    flow = '{k, m, t};
    dbus = '{da, da != 8'h00, 8'h05};
    @(negedge clk);
    flow = '0;
    dbus = '0;
    `CHK(rom_addr, rel ? last_a + ea : ea)
    `CHK(instr_valid, ev)
    `CHK(irq_ack, eack)
    if (ev) `CHK(instr, {3'b101, last_a})
  endtask
  // decoder noise during a dummy cycle must not load the counter; it only steps by one
  task automatic t_dummy;
    step(FLOW_JUMP, 0, 12'h123, 0, 0, 12'h123, 0, 0);
    while (phase !== 4'h8)
      @(negedge clk);
    `CHK(instr_valid, 1'b0)
    flow = '{FLOW_JUMP, 1'b0, 12'h456};
    dbus = '{8'h06, 1'b1, 8'h77};
    @(negedge clk);
    flow = '0;
    dbus = '0;
    `CHK(rom_addr, 12'h124)
    `CHK(instr_valid, 1'b1)
    `CHK(instr, {3'b101, 12'h123})
    $display("dummy test done");
  endtask
  task automatic t_flow;
    step(FLOW_NONE, 0, 0, 0, 1, 1, 1, 0);
    step(FLOW_JUMP, 0, 12'hf3e, 0, 0, 12'hf3e, 0, 0);
    step(FLOW_NONE, 0, 0, 0, 1, 1, 1, 0);
    step(FLOW_SKIP, 1, 0, 0, 1, 1, 0, 0);
    step(FLOW_SKIP, 0, 0, 0, 1, 1, 1, 0);
    step(FLOW_NONE, 0, 0, 8'h06, 0, 12'hf05, 0, 0);
    step(FLOW_NONE, 0, 0, 8'h07, 1, 1, 1, 0);
    @(negedge clk);
    `CHK(pc_low_byte, 8'h07)
    $display("flow test done");
  endtask
  task automatic t_vec;
    for (int i = 0; i < 6; i++)
    begin
      raise(6'(1 << i));
      step(FLOW_NONE, 0, 0, 0, 0, 12'(4 * (i + 1)), 0, 6'(1 << i));
      ra = last_a;
      step(FLOW_RET, 0, 0, 0, 0, ra, 0, 0);
    end
    $display("vector test done");
  endtask
  task automatic t_prio;
    irq_en = 6'h3c;
    raise(6'h3f);
    step(FLOW_NONE, 0, 0, 0, 0, 12'h00c, 0, 6'h04);
    irq_en = 6'h00;
    step(FLOW_NONE, 0, 0, 0, 1, 1, 1, 0);
    irq_en = 6'h3f;
    do_reset;
    $display("priority test done");
  endtask
  task automatic t_call;
    for (int i = 0; i < 6; i++)
    begin
      step(FLOW_CALL, 0, 12'(12'h200 + 16 * i), 0, 0, 12'(12'h200 + 16 * i), 0, 0);
      ra = last_a;
    end
    raise(6'h01);
    step(FLOW_NONE, 0, 0, 0, 1, 1, 1, 0);
    `CHK(stack_full, 1'b1)
    step(FLOW_RET, 0, 0, 0, 0, ra, 0, 0);
    step(FLOW_NONE, 0, 0, 0, 0, 12'h004, 0, 6'h01);
    $display("stack test done");
  endtask
  initial
  begin
    #80000;
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    final_report;
  end
  initial
  begin
    do_reset;
    t_flow;
    t_dummy;
    t_vec;
    t_prio;
    t_call;
    do_reset;
    final_report;
  end
endmodule
`default_nettype wire
